// >>> design/rsr_map.vh
// register offsets, field positions and reset values of the routing and symbol block
`ifndef RSR_MAP_VH
`define RSR_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RSR_REG_RCV_CFG   8'h38
`define RSR_REG_SIG_OUT   8'h39
`define RSR_REG_DRV_CON   8'h3a
`define RSR_REG_RX_CTRL   8'h3b
`define RSR_REG_SYM0_LO   8'h40
`define RSR_REG_SYM0_HI   8'h41
`define RSR_REG_SYM1_LO   8'h42
`define RSR_REG_SYM1_HI   8'h43
`define RSR_REG_SYM2      8'h44
`define RSR_REG_SYM3      8'h45
`define RSR_REG_LEN10     8'h46
`define RSR_REG_LEN32     8'h47
`define RSR_REG_BURST_CFG 8'h48
`define RSR_REG_BURST0    8'h49
`define RSR_REG_BURST1    8'h4a
`define RSR_REG_FRAME_CON 8'h4b
`define RSR_REG_CFG01     8'h4c
`define RSR_REG_CFG23     8'h4d
`define RSR_REG_STATUS    8'h4e
// ----------------------------------------
// field positions
// ----------------------------------------
`define RSR_RCV_SINGLE_BIT 0
`define RSR_RCV_ADC_BIT    1
`define RSR_RCV_SEL_LSB    2
`define RSR_DRV_ACTIVE_BIT 2
// ----------------------------------------
// select codes
// ----------------------------------------
`define RSR_OUT_TXDATA   4'h1
`define RSR_OUT_RXDATA   4'h2
`define RSR_OUT_ENVELOPE 4'h4
`define RSR_OUT_MANCH    4'h6
`define RSR_OUT_MANCH_SC 4'h7
`define RSR_IN_INTERNAL  2'h1
`define RSR_IN_SUBCARR   2'h2
`define RSR_IN_GENERIC   2'h3
`define RSR_TX_IDLE      2'h0
`define RSR_TX_INTERNAL  2'h1
`define RSR_TX_SIGNAL_IN_PIN     2'h2
// ----------------------------------------
// reset values
// ----------------------------------------
`define RSR_RST_BYTE     8'h00
`define RSR_RST_RCV_CFG  8'h04
`endif

// >>> design/rsr_sync2.v
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module rsr_sync2 #(
	parameter W = 1
) (
	input  wire         sys_clk,
	input  wire         reset_n,
	input  wire         clkEn,
	input  wire [W-1:0] asyncIn,
	output reg  [W-1:0] syncOut
);
	// ----------------------------------------
	// stages
	// ----------------------------------------
	reg [W-1:0] stage1_r;

	// first stage feeds only the second stage
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1_r <= {W{1'b0}};
			syncOut  <= {W{1'b0}};
		end else if (clkEn) begin
			stage1_r <= asyncIn;
			syncOut  <= stage1_r;
		end
	end
endmodule
`default_nettype wire

// >>> design/rsr_sym_engine.v
// serialiser for one pair of framing symbols: pattern then optional burst
`timescale 1ns/100ps
`default_nettype none
module rsr_sym_engine #(
	parameter PW        = 16,
	parameter LW        = 4,
	parameter HAS_BURST = 1
) (
	input  wire          sys_clk,
	input  wire          reset_n,
	input  wire          clkEn,
	input  wire          start,
	input  wire [PW-1:0] pattern,
	input  wire [LW-1:0] patLen,
	input  wire          burstEn,
	input  wire          burstVal,
	input  wire [7:0]    burstLen,
	input  wire [3:0]    bitDiv,
	output wire          busy,
	output reg           bitOut,
	output reg           bitStb,
	output reg           done
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	localparam [2:0] ST_IDLE  = 3'h1;
	localparam [2:0] ST_PAT   = 3'h2;
	localparam [2:0] ST_BURST = 3'h4;

	reg [2:0]    state_r;
	reg [PW-1:0] pat_r;
	reg [LW-1:0] idx_r;
	reg [7:0]    burstCnt_r;
	reg          burstVal_r;
	reg          burstEn_r;
	reg [3:0]    divCnt_r;
	wire         tick;

	assign busy = ~state_r[0];
	// bit clock shared by the pair; divider runs only while a symbol is out
	assign tick = (divCnt_r == bitDiv);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r    <= ST_IDLE;
			pat_r      <= {PW{1'b0}};
			idx_r      <= {LW{1'b0}};
			burstCnt_r <= 8'h00;
			burstVal_r <= 1'b0;
			burstEn_r  <= 1'b0;
			divCnt_r   <= 4'h0;
			bitOut     <= 1'b0;
			bitStb     <= 1'b0;
			done       <= 1'b0;
		end else if (clkEn) begin
			bitStb <= 1'b0;
			done   <= 1'b0;
			if (state_r != ST_IDLE)
				divCnt_r <= tick ? 4'h0 : divCnt_r + 4'h1;
			case (state_r)
			ST_IDLE: begin
				divCnt_r <= 4'h0;
				if (start) begin
					// latched so a register write mid-symbol cannot tear it
					pat_r      <= pattern;
					idx_r      <= patLen; // see (R14)
					burstEn_r  <= (HAS_BURST != 0) & burstEn; // see (R12)
					burstVal_r <= burstVal;
					burstCnt_r <= burstLen;
					state_r    <= ST_PAT;
				end
			end
			ST_PAT: begin
				if (tick) begin
					bitOut <= pat_r[idx_r]; // see (R13)
					bitStb <= 1'b1;
					if (idx_r == {LW{1'b0}}) begin
						if (burstEn_r) begin
							state_r <= ST_BURST; // see (R11)
						end else begin
							state_r <= ST_IDLE;
							done    <= 1'b1;
						end
					end else begin
						idx_r <= idx_r - {{(LW-1){1'b0}}, 1'b1};
					end
				end
			end
			ST_BURST: begin
				if (tick) begin
					bitOut <= burstVal_r; // see (R11)
					bitStb <= 1'b1;
					if (burstCnt_r == 8'h00) begin
						state_r <= ST_IDLE;
						done    <= 1'b1;
					end else begin
						burstCnt_r <= burstCnt_r - 8'h01;
					end
				end
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> design/rsr_top.v
// signal routing, receiver input selection and framing symbol generation
// ----------------------------------------
// Summary of operation
// (R1) single-ended bit: 0 differential pos/neg pins, 1 pins tied single-ended
// (R2) converter-mode bit routes raw I/Q mixer outputs straight to converter
// (R3) I and Q channels digitised and forwarded to the correlation stage
// (R4) signal out: 0100 envelope, 0110 Manchester, 0111 Manchester with subcarrier
// (R5) receive input: 01 internal, 10 signal-in subcarrier, 11 signal-in generic
// (R6) digital half: out 0100, input 10 or 11, transmit source 00 idle low
// (R7) antenna half: out 0110/0111, input 01, source 10 signal-in, multi-receive on
// (R8) out select 4 puts the Miller coder output on signal out
// (R9) passive and active front ends supported, operated one after another
// (R10) out select also shows internal transmit and receive data for test
// (R11) symbols zero and one: up to 16 bit pattern plus burst up to 256
// (R12) symbols two and three: up to 8 bit pattern, no burst
// (R13) last sent bit at register LSB, sent from high bits toward bit zero
// (R14) pattern length from pair length registers, higher bits ignored
// (R15) frame control: 0/1/2 before data, 1/2/3 after data
// (R16) pairs 0/1 and 2/3 each share one configuration set
// (R17) unlisted select codes drive signal out low, receive from internal path
// ----------------------------------------
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "rsr_map.vh"
module rsr_top #(
	parameter ADW = 8
) (
	input  wire           sys_clk,
	input  wire           reset_n,
	input  wire           clkEn,
	input  wire [7:0]     regAddr,
	input  wire [7:0]     regWrData,
	input  wire           regWrStb,
	input  wire           regRdStb,
	output reg  [7:0]     regRdData,
	input  wire           rxInPos,
	input  wire           rxInNeg,
	input  wire           signalInPin,
	output reg            signalOutPin,
	input  wire [ADW-1:0] mixRawI,
	input  wire [ADW-1:0] mixRawQ,
	input  wire [ADW-1:0] filtI,
	input  wire [ADW-1:0] filtQ,
	input  wire           sampleStb,
	output reg  [ADW-1:0] corrI,
	output reg  [ADW-1:0] corrQ,
	output reg            corrValid,
	input  wire           millerEnvelope,
	input  wire           manchRx,
	input  wire           manchSubRx,
	input  wire           txDataObs,
	input  wire           rxDataObs,
	output reg            rxData,
	output reg            rxGeneric,
	output reg            modDrive,
	output reg            activeModDrive,
	output wire           multiReceive,
	input  wire           frameStart,
	input  wire           frameEnd,
	output reg            symBit,
	output reg            symBitStb,
	output reg            symDone,
	output wire           symBusy,
	output reg  [7:0]     symCfg
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg  [7:0] rcvCfg_r;
	reg  [7:0] signal_out_pin_r;
	reg  [7:0] driver_control_r;
	reg  [7:0] receive_control_r;
	reg  [7:0] sym0Lo_r;
	reg  [7:0] sym0Hi_r;
	reg  [7:0] sym1Lo_r;
	reg  [7:0] sym1Hi_r;
	reg  [7:0] sym2_r;
	reg  [7:0] sym3_r;
	reg  [7:0] len10_r;
	reg  [7:0] len32_r;
	reg  [7:0] burstCfg_r;
	reg  [7:0] burst0_r;
	reg  [7:0] burst1_r;
	reg  [7:0] frameCon_r;
	reg  [7:0] cfg01_r;
	reg  [7:0] cfg23_r;
	reg  [7:0] rdMux;

	wire       rxSingle   = rcvCfg_r[`RSR_RCV_SINGLE_BIT];
	wire       adcDirect  = rcvCfg_r[`RSR_RCV_ADC_BIT];
	wire [1:0] rxInSel    = rcvCfg_r[`RSR_RCV_SEL_LSB+1:`RSR_RCV_SEL_LSB];
	wire [3:0] outPinSel  = signal_out_pin_r[3:0];
	wire [1:0] txSrcSel   = driver_control_r[1:0];
	wire       activeSide = driver_control_r[`RSR_DRV_ACTIVE_BIT];

	assign multiReceive = receive_control_r[0]; // see (R7)

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	wire [2:0] pinSync;
	wire       rxPosS  = pinSync[0];
	wire       rxNegS  = pinSync[1];
	wire       sigInS  = pinSync[2];

	rsr_sync2 #(
		.W (3)
	) u_pinSync (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.clkEn   (clkEn),
		.asyncIn ({signalInPin, rxInNeg, rxInPos}),
		.syncOut (pinSync)
	);

	// ----------------------------------------
	// symbol engines
	// ----------------------------------------
	wire        busyA;
	wire        busyB;
	wire        bitA;
	wire        bitB;
	wire        stbA;
	wire        stbB;
	wire        doneA;
	wire        doneB;
	reg  [1:0]  reqSym;
	reg         reqValid;
	reg         ownerB_r;
	wire        startA  = reqValid & ~reqSym[1];
	wire        startB  = reqValid & reqSym[1];
	wire        symOneA = reqSym[0];
	wire [15:0] patA    = symOneA ? {sym1Hi_r, sym1Lo_r} : {sym0Hi_r, sym0Lo_r};
	wire [3:0]  lenA    = symOneA ? len10_r[7:4] : len10_r[3:0];
	wire [7:0]  patB    = reqSym[0] ? sym3_r : sym2_r;
	wire [2:0]  lenB    = reqSym[0] ? len32_r[6:4] : len32_r[2:0];

	assign symBusy = busyA | busyB;

	// request decode; a request while a symbol is out is dropped
	always @* begin
		reqSym   = 2'h0;
		reqValid = 1'b0;
		if (!symBusy && frameStart && frameCon_r[1:0] != 2'h0) begin
			reqSym   = frameCon_r[1:0] - 2'h1; // see (R15)
			reqValid = 1'b1;
		end else if (!symBusy && frameEnd && frameCon_r[3:2] != 2'h0) begin
			reqSym   = frameCon_r[3:2]; // see (R15)
			reqValid = 1'b1;
		end
	end

	rsr_sym_engine #(
		.PW        (16),
		.LW        (4),
		.HAS_BURST (1)
	) u_engA (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.clkEn    (clkEn),
		.start    (startA),
		.pattern  (patA),
		.patLen   (lenA),
		.burstEn  (symOneA ? burstCfg_r[2] : burstCfg_r[0]),
		.burstVal (symOneA ? burstCfg_r[3] : burstCfg_r[1]),
		.burstLen (symOneA ? burst1_r : burst0_r),
		.bitDiv   (cfg01_r[3:0]),
		.busy     (busyA),
		.bitOut   (bitA),
		.bitStb   (stbA),
		.done     (doneA)
	); // see (R11) (R16)

	// burst inputs tied off: this pair has no burst extension
	rsr_sym_engine #(
		.PW        (8),
		.LW        (3),
		.HAS_BURST (0)
	) u_engB (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.clkEn    (clkEn),
		.start    (startB),
		.pattern  (patB),
		.patLen   (lenB),
		.burstEn  (1'b0),
		.burstVal (1'b0),
		.burstLen (8'h00),
		.bitDiv   (cfg23_r[3:0]),
		.busy     (busyB),
		.bitOut   (bitB),
		.bitStb   (stbB),
		.done     (doneB)
	); // see (R12) (R16)

	// ----------------------------------------
	// register write and read
	// ----------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rcvCfg_r   <= `RSR_RST_RCV_CFG;
			signal_out_pin_r   <= `RSR_RST_BYTE;
			driver_control_r   <= `RSR_RST_BYTE;
			receive_control_r   <= `RSR_RST_BYTE;
			sym0Lo_r   <= `RSR_RST_BYTE;
			sym0Hi_r   <= `RSR_RST_BYTE;
			sym1Lo_r   <= `RSR_RST_BYTE;
			sym1Hi_r   <= `RSR_RST_BYTE;
			sym2_r     <= `RSR_RST_BYTE;
			sym3_r     <= `RSR_RST_BYTE;
			len10_r    <= `RSR_RST_BYTE;
			len32_r    <= `RSR_RST_BYTE;
			burstCfg_r <= `RSR_RST_BYTE;
			burst0_r   <= `RSR_RST_BYTE;
			burst1_r   <= `RSR_RST_BYTE;
			frameCon_r <= `RSR_RST_BYTE;
			cfg01_r    <= `RSR_RST_BYTE;
			cfg23_r    <= `RSR_RST_BYTE;
			regRdData  <= 8'h00;
		end else if (clkEn) begin
			regRdData <= regRdStb ? rdMux : 8'h00;
			if (regWrStb) begin
				case (regAddr)
				`RSR_REG_RCV_CFG:   rcvCfg_r   <= {4'h0, regWrData[3:0]};
				`RSR_REG_SIG_OUT:   signal_out_pin_r   <= {4'h0, regWrData[3:0]};
				`RSR_REG_DRV_CON:   driver_control_r   <= {5'h00, regWrData[2:0]};
				`RSR_REG_RX_CTRL:   receive_control_r   <= {7'h00, regWrData[0]};
				`RSR_REG_SYM0_LO:   sym0Lo_r   <= regWrData;
				`RSR_REG_SYM0_HI:   sym0Hi_r   <= regWrData;
				`RSR_REG_SYM1_LO:   sym1Lo_r   <= regWrData;
				`RSR_REG_SYM1_HI:   sym1Hi_r   <= regWrData;
				`RSR_REG_SYM2:      sym2_r     <= regWrData;
				`RSR_REG_SYM3:      sym3_r     <= regWrData;
				`RSR_REG_LEN10:     len10_r    <= regWrData;
				`RSR_REG_LEN32:     len32_r    <= {1'b0, regWrData[6:4], 1'b0, regWrData[2:0]};
				`RSR_REG_BURST_CFG: burstCfg_r <= {4'h0, regWrData[3:0]};
				`RSR_REG_BURST0:    burst0_r   <= regWrData;
				`RSR_REG_BURST1:    burst1_r   <= regWrData;
				`RSR_REG_FRAME_CON: frameCon_r <= {4'h0, regWrData[3:0]};
				`RSR_REG_CFG01:     cfg01_r    <= regWrData;
				`RSR_REG_CFG23:     cfg23_r    <= regWrData;
				default: ;
				endcase
			end
		end
	end

	// unmapped addresses and the status register's spare bits read zero
	always @* begin
		case (regAddr)
		`RSR_REG_RCV_CFG:   rdMux = rcvCfg_r;
		`RSR_REG_SIG_OUT:   rdMux = signal_out_pin_r;
		`RSR_REG_DRV_CON:   rdMux = driver_control_r;
		`RSR_REG_RX_CTRL:   rdMux = receive_control_r;
		`RSR_REG_SYM0_LO:   rdMux = sym0Lo_r;
		`RSR_REG_SYM0_HI:   rdMux = sym0Hi_r;
		`RSR_REG_SYM1_LO:   rdMux = sym1Lo_r;
		`RSR_REG_SYM1_HI:   rdMux = sym1Hi_r;
		`RSR_REG_SYM2:      rdMux = sym2_r;
		`RSR_REG_SYM3:      rdMux = sym3_r;
		`RSR_REG_LEN10:     rdMux = len10_r;
		`RSR_REG_LEN32:     rdMux = len32_r;
		`RSR_REG_BURST_CFG: rdMux = burstCfg_r;
		`RSR_REG_BURST0:    rdMux = burst0_r;
		`RSR_REG_BURST1:    rdMux = burst1_r;
		`RSR_REG_FRAME_CON: rdMux = frameCon_r;
		`RSR_REG_CFG01:     rdMux = cfg01_r;
		`RSR_REG_CFG23:     rdMux = cfg23_r;
		`RSR_REG_STATUS:    rdMux = {3'h0, ownerB_r, signalOutPin, rxData, busyB, busyA};
		default:            rdMux = 8'h00;
		endcase
	end

	// ----------------------------------------
	// receive path and converter feed
	// ----------------------------------------
	// tied pins carry one level; otherwise the pair is compared
	wire analogRx = rxSingle ? rxPosS : (rxPosS & ~rxNegS); // see (R1)

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rxData    <= 1'b0;
			rxGeneric <= 1'b0;
			corrI     <= {ADW{1'b0}};
			corrQ     <= {ADW{1'b0}};
			corrValid <= 1'b0;
		end else if (clkEn) begin
			case (rxInSel)
			`RSR_IN_SUBCARR: begin
				rxData    <= sigInS; // see (R5) (R6)
				rxGeneric <= 1'b0;
			end
			`RSR_IN_GENERIC: begin
				rxData    <= sigInS; // see (R5) (R6)
				rxGeneric <= 1'b1;
			end
			default: begin
				rxData    <= analogRx; // see (R5) (R7) (R17)
				rxGeneric <= 1'b0;
			end
			endcase
			corrValid <= sampleStb; // see (R3)
			if (sampleStb) begin
				corrI <= adcDirect ? mixRawI : filtI; // see (R2) (R3)
				corrQ <= adcDirect ? mixRawQ : filtQ; // see (R2) (R3)
			end
		end
	end

	// ----------------------------------------
	// signal out, modulator source, symbol output
	// ----------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			signalOutPin   <= 1'b0;
			modDrive       <= 1'b0;
			activeModDrive <= 1'b0;
			ownerB_r       <= 1'b0;
			symBit         <= 1'b0;
			symBitStb      <= 1'b0;
			symDone        <= 1'b0;
			symCfg         <= 8'h00;
		end else if (clkEn) begin
			case (outPinSel)
			`RSR_OUT_ENVELOPE: signalOutPin <= millerEnvelope; // see (R4) (R6) (R8)
			`RSR_OUT_MANCH:    signalOutPin <= manchRx; // see (R4) (R7)
			`RSR_OUT_MANCH_SC: signalOutPin <= manchSubRx; // see (R4) (R7)
			`RSR_OUT_TXDATA:   signalOutPin <= txDataObs; // see (R10)
			`RSR_OUT_RXDATA:   signalOutPin <= rxDataObs; // see (R10)
			default:           signalOutPin <= 1'b0; // see (R17)
			endcase
			// one front end at a time: the idle one is held low
			case (txSrcSel)
			`RSR_TX_INTERNAL: begin
				modDrive       <= activeSide ? 1'b0 : millerEnvelope; // see (R9)
				activeModDrive <= activeSide ? millerEnvelope : 1'b0; // see (R9)
			end
			`RSR_TX_SIGNAL_IN_PIN: begin
				modDrive       <= activeSide ? 1'b0 : sigInS; // see (R7) (R9)
				activeModDrive <= activeSide ? sigInS : 1'b0; // see (R9)
			end
			default: begin
				modDrive       <= 1'b0; // see (R6)
				activeModDrive <= 1'b0;
			end
			endcase
			if (reqValid)
				ownerB_r <= reqSym[1];
			symBit    <= ownerB_r ? bitB : bitA;
			symBitStb <= stbA | stbB;
			symDone   <= doneA | doneB;
			symCfg    <= ownerB_r ? cfg23_r : cfg01_r; // see (R16)
		end
	end
endmodule
`default_nettype wire

// >>> test/rsr_top_monitor.sv
// assertion checker for the routing and symbol block
`timescale 1ns/100ps
`default_nettype none
module rsr_top_monitor #(
	parameter ADW = 8
) (
	input wire logic           sys_clk,
	input wire logic           reset_n,
	input wire logic           clkEn,
	input wire logic [7:0]     regAddr,
	input wire logic [7:0]     regWrData,
	input wire logic           regWrStb,
	input wire logic [ADW-1:0] mixRawI,
	input wire logic [ADW-1:0] filtI,
	input wire logic           sampleStb,
	input wire logic [ADW-1:0] corrI,
	input wire logic           corrValid,
	input wire logic           signalOutPin,
	input wire logic           millerEnvelope,
	input wire logic           manchRx,
	input wire logic           manchSubRx,
	input wire logic           txDataObs,
	input wire logic           rxDataObs,
	input wire logic           rxGeneric,
	input wire logic           modDrive,
	input wire logic           multiReceive,
	input wire logic           symBitStb,
	input wire logic           symDone,
	input wire logic           symBusy
);
	logic [7:0] rcv_r;
	logic [3:0] sel_r;
	logic [1:0] drv_r;
	logic       mrx_r;
	logic       selPin;
	// ----------------------------------------
	// shadow of the routing registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rcv_r <= 8'h04;
			sel_r <= 4'h0;
			drv_r <= 2'h0;
			mrx_r <= 1'b0;
		end else if (clkEn && regWrStb) begin
			case (regAddr)
				8'h38: rcv_r <= regWrData;
				8'h39: sel_r <= regWrData[3:0];
				8'h3a: drv_r <= regWrData[1:0];
				8'h3b: mrx_r <= regWrData[0];
				default: ;
			endcase
		end
	end
	// unlisted codes fall to low so the pin never floats between modes
	always_comb begin
		case (sel_r)
			4'h1: selPin = txDataObs;
			4'h2: selPin = rxDataObs;
			4'h4: selPin = millerEnvelope;
			4'h6: selPin = manchRx;
			4'h7: selPin = manchSubRx;
			default: selPin = 1'b0;
		endcase
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_req; $rose(symBusy); endsequence
	sequence s_bit; symBitStb; endsequence
	property p_env; clkEn && sel_r == 4'h4 |=> signalOutPin == $past(millerEnvelope); endproperty
	property p_obs; clkEn && (sel_r == 4'h1 || sel_r == 4'h2) |=> signalOutPin == $past(selPin); endproperty
	property p_route; clkEn |=> signalOutPin == $past(selPin); endproperty
	property p_generic; clkEn |=> rxGeneric == ($past(rcv_r[3:2]) == 2'h3); endproperty
	property p_idle_tx; clkEn && drv_r[0] == drv_r[1] |=> !modDrive; endproperty
	property p_multi; multiReceive == mrx_r; endproperty
	property p_conv; clkEn && sampleStb |=> corrValid && corrI == ($past(rcv_r[1]) ? $past(mixRawI) : $past(filtI)); endproperty
	property p_corr_one; clkEn && !sampleStb |=> !corrValid; endproperty
	property p_first_bit; s_req |-> ##[1:20] s_bit; endproperty
	property p_last_bit; symDone |-> symBitStb; endproperty
	a_env: assert property (p_env) else $error("envelope not on signal out");
	a_obs: assert property (p_obs) else $error("observe data not on signal out");
	a_route: assert property (p_route) else $error("signal out mux wrong");
	a_generic: assert property (p_generic) else $error("generic flag wrong");
	a_idle_tx: assert property (p_idle_tx) else $error("drivers not idle low");
	a_multi: assert property (p_multi) else $error("multi receive differs");
	a_conv: assert property (p_conv) else $error("converter input wrong");
	a_corr_one: assert property (p_corr_one) else $error("stray correlator sample");
	a_first_bit: assert property (p_first_bit) else $error("symbol never starts");
	a_last_bit: assert property (p_last_bit) else $error("done without bit");
endmodule
bind rsr_top rsr_top_monitor #(.ADW(ADW)) rsr_top_monitor_i (
	.sys_clk, .reset_n, .clkEn, .regAddr, .regWrData, .regWrStb, .mixRawI, .filtI, .sampleStb,
	.corrI, .corrValid, .signalOutPin, .millerEnvelope, .manchRx, .manchSubRx, .txDataObs,
	.rxDataObs, .rxGeneric, .modDrive, .multiReceive, .symBitStb, .symDone, .symBusy
);
`default_nettype wire

// >>> test/rsr_far_half.sv
// model of the other reader half on the signal pins
`timescale 1ns/100ps
`default_nettype none
module rsr_far_half (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic active,
	input  wire logic antennaRole,
	input  wire logic fromDut,
	output var  logic toDut
);
	logic [7:0] pat_r;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pat_r <= 8'h9d;
			toDut <= 1'b0;
		end else if (!active) begin
			toDut <= 1'b0;
		end else if (antennaRole) begin
			toDut <= fromDut;
		end else begin
			pat_r <= {pat_r[6:0], pat_r[7] ^ pat_r[5]};
			toDut <= pat_r[7];
		end
	end
endmodule
`default_nettype wire

// >>> test/rsr_top_tb_top.sv
// self-checking bench for the routing and symbol block
`timescale 1ns/100ps
`default_nettype none
module rsr_top_tb_top;
	logic            sys_clk, reset_n, clkEn, regWrStb, regRdStb, rxInPos, rxInNeg, sampleStb;
	logic            millerEnvelope, manchRx, manchSubRx, txDataObs, rxDataObs, frameStart, frameEnd;
	logic            farOn, farAnt;
	logic [7:0]      regAddr, regWrData, mixRawI, mixRawQ, filtI, filtQ, rdVal;
	logic [2:0]      hist;
	wire logic       signalInPin, signalOutPin, corrValid, rxData, rxGeneric, modDrive, activeModDrive;
	wire logic       multiReceive, symBit, symBitStb, symDone, symBusy;
	wire logic [7:0] regRdData, corrI, corrQ, symCfg;
	int              error_cnt, cmp_count;
	rsr_top #(.ADW(8)) rsr_top_i (
		.sys_clk, .reset_n, .clkEn, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
		.rxInPos, .rxInNeg, .signalInPin, .signalOutPin, .mixRawI, .mixRawQ, .filtI, .filtQ,
		.sampleStb, .corrI, .corrQ, .corrValid, .millerEnvelope, .manchRx, .manchSubRx,
		.txDataObs, .rxDataObs, .rxData, .rxGeneric, .modDrive, .activeModDrive, .multiReceive,
		.frameStart, .frameEnd, .symBit, .symBitStb, .symDone, .symBusy, .symCfg
	);
	rsr_far_half rsr_far_half_i (.sys_clk, .reset_n, .active(farOn), .antennaRole(farAnt),
		.fromDut(signalOutPin), .toDut(signalInPin));
	// pin inputs pass two sync stages and the output register
	always @(posedge sys_clk) hist <= {hist[1:0], signalInPin};
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge sys_clk);
		regWrStb <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge sys_clk);
		regRdStb <= 1'b0;
		@(negedge sys_clk);
		d = regRdData;
	endtask
	task follow(input int n, input logic useMod);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			millerEnvelope <= ~millerEnvelope;
			@(negedge sys_clk);
			chk(useMod ? modDrive : rxData, hist[2], "pin path");
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		rd(8'h38, rdVal);
		chk(rdVal, 8'h04, "rcv reset");
		rd(8'h50, rdVal);
		chk(rdVal, 8'h00, "unmapped read");
		wr(8'h3b, 8'h01);
		rd(8'h3b, rdVal);
		chk(rdVal, 8'h01, "rx ctrl");
	endtask
	task t_outsel;
		logic e;
		for (int i = 0; i < 32; i++) begin
			wr(8'h39, {4'h0, i[4:1]});
			@(posedge sys_clk);
			{millerEnvelope, manchRx, manchSubRx, txDataObs, rxDataObs} <= i[0] ? 5'h15 : 5'h0a;
			repeat (2) @(posedge sys_clk);
			@(negedge sys_clk);
			e = (i[4:1] inside {4'h2, 4'h4, 4'h7}) ? i[0] : (i[4:1] inside {4'h1, 4'h6}) ? !i[0] : 1'b0;
			chk(signalOutPin, e, "out select");
		end
	endtask
	task t_rxin;
		for (int m = 0; m < 4; m++) begin
			wr(8'h38, m[1] ? 8'h05 : 8'h04);
			@(posedge sys_clk);
			rxInPos <= (m != 3);
			rxInNeg <= (m != 0);
			repeat (5) @(posedge sys_clk);
			@(negedge sys_clk);
			chk(rxData, m == 0 || m == 2, "rx internal");
		end
		@(posedge sys_clk);
		farOn <= 1'b1;
		for (int m = 2; m < 4; m++) begin
			wr(8'h38, {4'h0, m[1:0], 2'h0});
			follow(12, 1'b0);
			chk(rxGeneric, m == 3, "rx generic");
		end
	endtask
	task t_split;
		wr(8'h38, 8'h04);
		wr(8'h39, 8'h06);
		wr(8'h3a, 8'h02);
		follow(12, 1'b1);
		chk(multiReceive, 1'b1, "multi rx");
		wr(8'h3a, 8'h06);
		repeat (2) @(negedge sys_clk);
		chk({activeModDrive, modDrive}, {hist[2], 1'b0}, "active drive");
		wr(8'h3a, 8'h00);
		wr(8'h39, 8'h04);
		wr(8'h38, 8'h08);
		@(posedge sys_clk);
		farAnt <= 1'b1;
		follow(12, 1'b0);
		chk(modDrive, 1'b0, "tx idle");
		chk(signalOutPin, !millerEnvelope, "envelope out");
		wr(8'h3a, 8'h01);
		repeat (2) @(negedge sys_clk);
		chk({modDrive, activeModDrive}, {millerEnvelope, 1'b0}, "internal drive");
	endtask
	task t_corr;
		@(posedge sys_clk);
		{mixRawI, mixRawQ, filtI, filtQ} <= 32'hc3a53c5a;
		for (int m = 0; m < 2; m++) begin
			wr(8'h38, m ? 8'h06 : 8'h04);
			@(posedge sys_clk);
			sampleStb <= 1'b1;
			@(posedge sys_clk);
			sampleStb <= 1'b0;
			@(negedge sys_clk);
			chk({corrValid, corrI, corrQ}, m ? 17'h1c3a5 : 17'h13c5a, "correlator");
		end
	endtask
	task symrun(input logic post, input logic [31:0] exp, input int n, input logic [7:0] cfg);
		logic [31:0] got;
		int          k;
		got = '0;
		k = 0;
		@(posedge sys_clk);
		frameStart <= !post;
		frameEnd <= post;
		@(posedge sys_clk);
		frameStart <= 1'b0;
		frameEnd <= 1'b0;
		for (int t = 0; t < 200 && symDone !== 1'b1; t++) begin
			@(negedge sys_clk);
			if (symBitStb === 1'b1) begin
				got = {got[30:0], symBit};
				k++;
			end
		end
		chk(got, exp, "symbol bits");
		chk(k, n, "symbol count");
		if (n != 0)
			chk(symCfg, cfg, "pair config");
	endtask
	task t_sym;
		logic [15:0] tab [14];
		tab = '{16'h40a5, 16'h41f3, 16'h4201, 16'h4380, 16'h44e9, 16'h45fc, 16'h46f9,
			16'h4735, 16'h4807, 16'h4902, 16'h4a01, 16'h4c30, 16'h4d51, 16'h4b01};
		foreach (tab[i])
			wr(tab[i][15:8], tab[i][7:0]);
		symrun(1'b0, 32'h1d2f, 13, 8'h30);
		wr(8'h4b, 8'h04);
		symrun(1'b1, 32'h20004, 18, 8'h30);
		wr(8'h4b, 8'h0f);
		symrun(1'b0, 32'h29, 6, 8'h51);
		symrun(1'b1, 32'h0c, 4, 8'h51);
		wr(8'h4b, 8'h00);
		symrun(1'b0, 32'h0, 0, 8'h00);
	endtask
	initial begin
		#200000;
		error_cnt++;
		end_sim;
	end
	initial begin
		reset_n = 1'b0;
		clkEn = 1'b1;
		{regWrStb, regRdStb, rxInPos, rxInNeg, sampleStb, frameStart, frameEnd, farOn, farAnt} = '0;
		{millerEnvelope, manchRx, manchSubRx, txDataObs, rxDataObs} = '0;
		{regAddr, regWrData, mixRawI, mixRawQ, filtI, filtQ} = '0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_regs;
		t_outsel;
		t_rxin;
		t_split;
		t_corr;
		t_sym;
		end_sim;
	end
endmodule
`default_nettype wire
